/* verilog/dmsc_mode_status.sv */
`timescale 1ns/100ps
`include "dmsc_consts.svh"
module dmsc_mode_status (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // special function register bus
   input wire dmsc_pkg::dmsc_sfr_s sfr,
   output logic [7:0] sfr_rdata_ff,
   // converter configuration
   input wire logic primary_ext_ref_select,
   input wire logic auxiliary_ext_ref_select,
   input wire logic aux_temp_selected,
   input wire logic auxiliary_config_wr,
   input wire logic ref_low,
   // modulator samples
   input wire dmsc_pkg::dmsc_sample_s primary_sample,
   input wire dmsc_pkg::dmsc_sample_s auxiliary_sample,
   // modulator control
   output logic primary_mod_reset_ff,
   output logic auxiliary_mod_reset_ff,
   output logic [2:0] input_connect_ff
);
   import dmsc_pkg::*;
   //------------------------------------------------------------
   // register decode
   //------------------------------------------------------------
   logic [7:0] mode_ff;
   logic cal_ff;
   logic p_rdy, a_rdy, p_err, a_err, p_cal, a_cal, p_mrst, a_mrst;
   logic [15:0] p_res, a_res, p_ofs, a_ofs, p_gn, a_gn;
   logic [1:0] align_ff;
   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      hit = (a == b);
   endfunction : hit
   // high-byte write keeps the stored low byte
   function automatic logic [7:0] p_ofs_lo_sel(input logic [7:0] a, input logic [15:0] o, input logic [15:0] g);
      p_ofs_lo_sel = a[3] ? g[7:0] : o[7:0];
   endfunction : p_ofs_lo_sel
   wire logic mode_wr = sfr.wr && hit(sfr.addr, `DMSC_ADDR_MODE);
   wire logic stat_wr = sfr.wr && hit(sfr.addr, `DMSC_ADDR_STAT);
   wire logic [7:0] mode_wval = sfr.wdata & `DMSC_MODE_MASK;
   wire logic [2:0] md = mode_ff[2:0];
   wire logic p_en = mode_ff[`DMSC_BIT_P_EN];
   wire logic a_en = mode_ff[`DMSC_BIT_A_EN];
   wire logic starts = mode_wr && (mode_wval[2:0] != DMSC_PWRDN) && (mode_wval[2:0] != DMSC_IDLE);
   wire logic any_active = (p_en || a_en) && (md != DMSC_PWRDN);
   wire logic noref = ref_low && any_active;
   wire logic a_enable_rise = mode_wr && mode_wval[`DMSC_BIT_A_EN] && !a_en;
   wire logic a_restart = (auxiliary_config_wr || a_enable_rise) && !mode_wr;
   wire logic p_ref_force = noref && primary_ext_ref_select;
   wire logic a_ref_force = noref && auxiliary_ext_ref_select;
   wire logic p_fin = p_en && primary_sample.done && !starts && md != DMSC_IDLE && md != DMSC_PWRDN;
   wire logic a_fin = a_en && auxiliary_sample.done && !starts && align_ff == 2'h0
      && md != DMSC_IDLE && md != DMSC_PWRDN;
   wire logic p_busy = p_en && !(p_fin || p_rdy);
   wire logic a_busy = a_en && !(a_fin || a_rdy);
   // one-shot modes drop back to power-down when all enabled channels finish
   wire logic oneshot_end = (md == DMSC_SINGLE || md[2]) && (p_en || a_en) && !p_busy && !a_busy
      && (p_fin || a_fin) && !mode_wr;
   dmsc_sample_s a_gated;
   assign a_gated = '{done: a_fin, clamp: auxiliary_sample.clamp, value: auxiliary_sample.value};
   wire logic p_temp = 1'b0;
   // a starting write clears ready of each channel it enables; a calibration write clears both
   wire logic cal_wr = starts && mode_wval[2];
   wire logic p_rdy_clr = (stat_wr && !sfr.wdata[`DMSC_BIT_P_RDY])
      || (starts && mode_wval[`DMSC_BIT_P_EN]) || cal_wr;
   wire logic a_rdy_clr = (stat_wr && !sfr.wdata[`DMSC_BIT_A_RDY])
      || (starts && mode_wval[`DMSC_BIT_A_EN]) || cal_wr;
   dmsc_conv_chan u_primary (
      .ref_clk(ref_clk), .rst(rst), .enable(p_en), .mode(md), .start(starts),
      .ready_clr(p_rdy_clr), .temp_sel(p_temp), .ref_force(p_ref_force),
      .ofs_wr(sfr.wr && hit(sfr.addr, `DMSC_ADDR_P_OFS_H)), .gn_wr(sfr.wr && hit(sfr.addr, `DMSC_ADDR_P_GN_H)),
      .coef_wdata({sfr.wdata, p_ofs_lo_sel(sfr.addr, p_ofs, p_gn)}), .sample(primary_sample),
      .ready_ff(p_rdy), .error_ff(p_err), .cal_done(p_cal), .mod_reset(p_mrst),
      .result_ff(p_res), .offset_ff(p_ofs), .gain_ff(p_gn)
   );
   dmsc_conv_chan u_auxiliary (
      .ref_clk(ref_clk), .rst(rst), .enable(a_en), .mode(md), .start(starts),
      .ready_clr(a_rdy_clr), .temp_sel(aux_temp_selected), .ref_force(a_ref_force),
      .ofs_wr(sfr.wr && hit(sfr.addr, `DMSC_ADDR_A_OFS_H)), .gn_wr(sfr.wr && hit(sfr.addr, `DMSC_ADDR_A_GN_H)),
      .coef_wdata({sfr.wdata, p_ofs_lo_sel(sfr.addr, a_ofs, a_gn)}), .sample(a_gated),
      .ready_ff(a_rdy), .error_ff(a_err), .cal_done(a_cal), .mod_reset(a_mrst),
      .result_ff(a_res), .offset_ff(a_ofs), .gain_ff(a_gn)
   );
   //------------------------------------------------------------
   // mode and status registers
   //------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mode_ff <= `DMSC_MODE_RST;
      end else if (mode_wr) begin
         mode_ff <= mode_wval;
      end else if (oneshot_end) begin
         mode_ff <= {mode_ff[7:3], DMSC_PWRDN};
      end
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cal_ff <= 1'b0;
      end else if (p_cal || a_cal) begin
         cal_ff <= 1'b1;
      end else if (starts) begin
         cal_ff <= 1'b0;
      end
   end
   // auxiliary falls into step with primary outputs after its own restart
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         align_ff <= 2'h0;
      end else if (a_restart) begin
         align_ff <= `DMSC_AUX_ALIGN;
      end else if (mode_wr) begin
         align_ff <= 2'h0;
      end else if (primary_sample.done && align_ff != 2'h0) begin
         align_ff <= align_ff - 2'h1;
      end
   end
   wire logic [7:0] stat_val = {p_rdy, a_rdy, cal_ff, noref, p_err, a_err, 2'b00};
   logic [7:0] rd_mux;
   always_comb begin
      case (sfr.addr)
         `DMSC_ADDR_MODE: rd_mux = mode_ff;
         `DMSC_ADDR_STAT: rd_mux = stat_val;
         `DMSC_ADDR_P_RES_H: rd_mux = p_res[15:8];
         `DMSC_ADDR_P_RES_M: rd_mux = p_res[7:0];
         `DMSC_ADDR_A_RES_H: rd_mux = a_res[15:8];
         `DMSC_ADDR_A_RES_L: rd_mux = a_res[7:0];
         `DMSC_ADDR_P_OFS_H: rd_mux = p_ofs[15:8];
         `DMSC_ADDR_P_OFS_M: rd_mux = p_ofs[7:0];
         `DMSC_ADDR_A_OFS_H: rd_mux = a_ofs[15:8];
         `DMSC_ADDR_A_OFS_L: rd_mux = a_ofs[7:0];
         `DMSC_ADDR_P_GN_H: rd_mux = p_gn[15:8];
         `DMSC_ADDR_P_GN_M: rd_mux = p_gn[7:0];
         `DMSC_ADDR_A_GN_H: rd_mux = a_gn[15:8];
         `DMSC_ADDR_A_GN_L: rd_mux = a_gn[7:0];
         default: rd_mux = 8'h00;
      endcase
   end
   wire logic [2:0] conn = (md == DMSC_ZS_INT) ? 3'h1 :
      (md == DMSC_FS_INT) ? {1'b1, auxiliary_ext_ref_select, primary_ext_ref_select} : 3'h0;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sfr_rdata_ff <= 8'h00;
         primary_mod_reset_ff <= 1'b1;
         auxiliary_mod_reset_ff <= 1'b1;
         input_connect_ff <= 3'h0;
      end else begin
         sfr_rdata_ff <= rd_mux;
         // every mode write resets both, even one that stops conversion
         primary_mod_reset_ff <= p_mrst || mode_wr;
         auxiliary_mod_reset_ff <= a_mrst || a_restart || mode_wr;
         input_connect_ff <= conn;
      end
   end
   a_mode_write_reset: assert property (@(posedge ref_clk) disable iff (rst)
      mode_wr |=> primary_mod_reset_ff && auxiliary_mod_reset_ff) else $error("mode write did not reset");
   a_single_returns: assert property (@(posedge ref_clk) disable iff (rst)
      oneshot_end |=> mode_ff[2:0] == 3'b000) else $error("one-shot did not return to power-down");
   a_reserved_zero: assert property (@(posedge ref_clk) disable iff (rst)
      (mode_ff & ~`DMSC_MODE_MASK) == 8'h00 && stat_val[1:0] == 2'b00) else $error("reserved bit set");
   a_noref_idle: assert property (@(posedge ref_clk) disable iff (rst)
      !any_active |-> !stat_val[`DMSC_BIT_NOREF]) else $error("reference flag while inactive");
   a_cal_kept: assert property (@(posedge ref_clk) disable iff (rst)
      cal_ff && !starts |=> cal_ff) else $error("calibration flag lost");
   a_cal_clears_rdy: assert property (@(posedge ref_clk) disable iff (rst)
      cal_wr |=> !p_rdy && !a_rdy) else $error("ready not cleared by calibration write");
endmodule : dmsc_mode_status

/* verilog/dmsc_consts.svh */
`ifndef DMSC_CONSTS_SVH
`define DMSC_CONSTS_SVH
`define DMSC_ADDR_MODE 8'hd1
`define DMSC_ADDR_STAT 8'hd8
`define DMSC_ADDR_P_RES_H 8'hdb
`define DMSC_ADDR_P_RES_M 8'hda
`define DMSC_ADDR_A_RES_H 8'hdd
`define DMSC_ADDR_A_RES_L 8'hdc
`define DMSC_ADDR_P_OFS_H 8'he3
`define DMSC_ADDR_P_OFS_M 8'he2
`define DMSC_ADDR_A_OFS_H 8'he5
`define DMSC_ADDR_A_OFS_L 8'he4
`define DMSC_ADDR_P_GN_H 8'heb
`define DMSC_ADDR_P_GN_M 8'hea
`define DMSC_ADDR_A_GN_H 8'hed
`define DMSC_ADDR_A_GN_L 8'hec
`define DMSC_MODE_RST 8'h00
`define DMSC_STAT_RST 8'h00
`define DMSC_MODE_MASK 8'h37
`define DMSC_BIT_P_EN 5
`define DMSC_BIT_A_EN 4
`define DMSC_BIT_P_RDY 7
`define DMSC_BIT_A_RDY 6
`define DMSC_BIT_CAL 5
`define DMSC_BIT_NOREF 4
`define DMSC_BIT_P_ERR 3
`define DMSC_BIT_A_ERR 2
`define DMSC_COEF_RST 16'h8000
`define DMSC_GAIN_RST 16'h5555
`define DMSC_ONES 16'hffff
`define DMSC_AUX_ALIGN 2'h3
`endif

/* verilog/dmsc_pkg.sv */
package dmsc_pkg;
   typedef enum logic [2:0] {
      DMSC_PWRDN = 3'b000,
      DMSC_IDLE = 3'b001,
      DMSC_SINGLE = 3'b010,
      DMSC_CONT = 3'b011,
      DMSC_ZS_INT = 3'b100,
      DMSC_FS_INT = 3'b101,
      DMSC_ZS_SYS = 3'b110,
      DMSC_FS_SYS = 3'b111
   } dmsc_mode_e;
   typedef struct packed {
      logic done;
      logic clamp;
      logic [15:0] value;
   } dmsc_sample_s;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dmsc_sfr_s;
endpackage : dmsc_pkg

/* verilog/dmsc_conv_chan.sv */
`timescale 1ns/100ps
`include "dmsc_consts.svh"
// one converter channel: result and coefficients with ready/error handling
module dmsc_conv_chan (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // control
   input wire logic enable,
   input wire logic [2:0] mode,
   input wire logic start,
   input wire logic ready_clr,
   input wire logic temp_sel,
   input wire logic ref_force,
   // coefficient writes from software
   input wire logic ofs_wr,
   input wire logic gn_wr,
   input wire logic [15:0] coef_wdata,
   // modulator sample
   input wire dmsc_pkg::dmsc_sample_s sample,
   // outputs
   output logic ready_ff,
   output logic error_ff,
   output logic cal_done,
   output logic mod_reset,
   output logic [15:0] result_ff,
   output logic [15:0] offset_ff,
   output logic [15:0] gain_ff
);
   import dmsc_pkg::*;
   wire logic is_cal = mode[2];
   wire logic active = enable && (mode != DMSC_PWRDN) && (mode != DMSC_IDLE);
   // idle and power-down keep filter in reset
   wire logic hold_rst = !active || start;
   wire logic fin = active && sample.done && !start;
   // no update while ready still set
   wire logic may_wr = !ready_ff;
   wire logic cal_fail = is_cal && temp_sel;
   wire logic [15:0] res_val = ref_force ? `DMSC_ONES : sample.value;
   wire logic res_clamp = ref_force || sample.clamp;
   assign mod_reset = hold_rst;
   assign cal_done = fin && is_cal;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ready_ff <= 1'b0;
      end else if (fin) begin
         ready_ff <= 1'b1;
      end else if (ready_clr || (start && enable)) begin
         ready_ff <= 1'b0;
      end
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         error_ff <= 1'b0;
      end else if (fin && (is_cal ? (cal_fail || sample.clamp) : (may_wr && res_clamp))) begin
         error_ff <= 1'b1;
      end else if (start) begin
         error_ff <= 1'b0;
      end
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         result_ff <= 16'h0000;
      end else if (fin && !is_cal && may_wr) begin
         result_ff <= res_val;
      end
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         offset_ff <= `DMSC_COEF_RST;
      end else if (ofs_wr) begin
         offset_ff <= coef_wdata;
      end else if (fin && may_wr && !cal_fail && !sample.clamp && !mode[0] && is_cal) begin
         offset_ff <= sample.value;
      end
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         gain_ff <= `DMSC_GAIN_RST;
      end else if (gn_wr) begin
         gain_ff <= coef_wdata;
      end else if (fin && may_wr && !cal_fail && !sample.clamp && mode[0] && is_cal) begin
         gain_ff <= sample.value;
      end
   end
   a_ready_blocks: assert property (@(posedge ref_clk) disable iff (rst)
      $past(ready_ff) && !$past(start) && !$past(ofs_wr) |-> $stable(offset_ff)) else $error("offset written while ready");
   a_start_clears_err: assert property (@(posedge ref_clk) disable iff (rst)
      start && !fin |=> !error_ff) else $error("error not cleared by start");
   a_done_sets_ready: assert property (@(posedge ref_clk) disable iff (rst)
      fin |=> ready_ff) else $error("ready not set on completion");
endmodule : dmsc_conv_chan

/* test/dmsc_sample_src.sv */
`timescale 1ns/100ps
// ----------------------------------------
// filter output model: one done pulse per period while out of reset
// ----------------------------------------
module dmsc_sample_src #(
   parameter int PERIOD = 6
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // control and stimulus
   input wire logic mod_reset,
   input wire logic clamp,
   input wire logic [15:0] value,
   // filter output
   output dmsc_pkg::dmsc_sample_s sample
);
   import dmsc_pkg::*;
   logic [7:0] cnt_ff;
   wire logic fire = !mod_reset && cnt_ff == 8'(PERIOD - 1);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= 8'h00;
      end else if (mod_reset || fire) begin
         cnt_ff <= 8'h00;
      end else begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end
   // input held steady by the bench before calibrations start; between pulses the value wobbles
   assign sample = '{done: fire, clamp: fire && clamp, value: fire ? value : ~value ^ {8'h00, cnt_ff}};
endmodule : dmsc_sample_src

/* test/dmsc_mode_status_bench.sv */
`timescale 1ns/100ps
`include "dmsc_consts.svh"
module dmsc_mode_status_bench;
   import dmsc_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   dmsc_sfr_s sfr = '0;
   logic [7:0] sfr_rdata_ff;
   logic p_ext = 1'b0;
   logic ref_low = 1'b0;
   logic clamp = 1'b0;
   logic aux_temp = 1'b0;
   logic aux_cfg_wr = 1'b0;
   logic [15:0] pval = 16'h0000;
   logic [15:0] v1;
   dmsc_sample_s p_smp;
   dmsc_sample_s a_smp;
   logic p_mrst;
   logic a_mrst;
   logic [2:0] conn;
   logic [15:0] exp_q[$];
   logic seen_rd;
   logic [15:0] note;
   int failures = 0;
   int samples_checked = 0;
   always #20 ref_clk = ~ref_clk;
   dmsc_mode_status DUT (.ref_clk(ref_clk), .rst(rst), .sfr(sfr), .sfr_rdata_ff(sfr_rdata_ff),
      .primary_ext_ref_select(p_ext), .auxiliary_ext_ref_select(1'b0), .aux_temp_selected(aux_temp),
      .auxiliary_config_wr(aux_cfg_wr), .ref_low(ref_low), .primary_sample(p_smp), .auxiliary_sample(a_smp),
      .primary_mod_reset_ff(p_mrst), .auxiliary_mod_reset_ff(a_mrst), .input_connect_ff(conn));
   dmsc_sample_src u_psrc (.ref_clk(ref_clk), .rst(rst), .mod_reset(p_mrst), .clamp(clamp), .value(pval),
      .sample(p_smp));
   dmsc_sample_src u_asrc (.ref_clk(ref_clk), .rst(rst), .mod_reset(a_mrst), .clamp(1'b0), .value(~pval),
      .sample(a_smp));
   // ----------------------------------------
   // bus tasks and comparison
   // ----------------------------------------
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      sfr.wr = 1'b1;
      sfr.addr = a;
      sfr.wdata = d;
      @(posedge ref_clk);
      #1;
      sfr.wr = 1'b0;
   endtask : wr
   // mask and expected value go on the queue for the monitor
   task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge ref_clk);
      #1;
      sfr.rd = 1'b1;
      sfr.addr = a;
      exp_q.push_back({m, e});
      @(posedge ref_clk);
      #1;
      sfr.rd = 1'b0;
   endtask : rd
   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : idle
   task automatic print_verdict;
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : print_verdict
   // ----------------------------------------
   // monitor: read data lands one cycle after the address
   // ----------------------------------------
   always @(posedge ref_clk) begin
      seen_rd = sfr.rd;
      #2;
      if (seen_rd === 1'b1 && exp_q.size() > 0) begin
         note = exp_q.pop_front();
         check("read data", sfr_rdata_ff & note[15:8], note[7:0]);
      end
   end
   initial begin
      #(40 * 3000);
      failures++;
      print_verdict();
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      void'($urandom(32'h2734));
      repeat (2) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      rd(`DMSC_ADDR_MODE, 8'hff, 8'h00);
      rd(`DMSC_ADDR_STAT, 8'hff, 8'h00);
      rd(`DMSC_ADDR_P_OFS_H, 8'hff, 8'h80);
      rd(`DMSC_ADDR_A_GN_L, 8'hff, 8'h55);
      rd(8'hd0, 8'hff, 8'h00);
      wr(`DMSC_ADDR_MODE, 8'hc8);
      rd(`DMSC_ADDR_MODE, 8'hff, 8'h00);
      wr(`DMSC_ADDR_P_OFS_H, 8'h12);
      rd(`DMSC_ADDR_P_OFS_H, 8'hff, 8'h12);
      rd(`DMSC_ADDR_P_OFS_M, 8'hff, 8'h00);
      // no enable bit: both converters stay down
      wr(`DMSC_ADDR_MODE, 8'h03);
      idle(16);
      rd(`DMSC_ADDR_STAT, 8'hff, 8'h00);
      check("aux filter reset", {7'h00, a_mrst}, 8'h01);
      wr(`DMSC_ADDR_MODE, 8'h21);
      idle(8);
      check("primary filter reset", {7'h00, p_mrst}, 8'h01);
      // single conversion
      pval = 16'($urandom());
      wr(`DMSC_ADDR_MODE, 8'h22);
      idle(16);
      rd(`DMSC_ADDR_STAT, 8'hff, 8'h80);
      rd(`DMSC_ADDR_MODE, 8'hff, 8'h20);
      rd(`DMSC_ADDR_P_RES_H, 8'hff, pval[15:8]);
      rd(`DMSC_ADDR_P_RES_M, 8'hff, pval[7:0]);
      // continuous: held result until ready is cleared
      v1 = 16'($urandom());
      pval = v1;
      wr(`DMSC_ADDR_MODE, 8'h23);
      idle(10);
      pval = ~v1;
      idle(14);
      rd(`DMSC_ADDR_P_RES_H, 8'hff, v1[15:8]);
      wr(`DMSC_ADDR_STAT, 8'h00);
      idle(10);
      rd(`DMSC_ADDR_P_RES_H, 8'hff, pval[15:8]);
      // clamped result raises the error flag
      clamp = 1'b1;
      wr(`DMSC_ADDR_MODE, 8'h22);
      idle(16);
      rd(`DMSC_ADDR_STAT, 8'hff, 8'h88);
      clamp = 1'b0;
      ref_low = 1'b1;
      p_ext = 1'b1;
      wr(`DMSC_ADDR_MODE, 8'h23);
      rd(`DMSC_ADDR_STAT, 8'h08, 8'h00);
      idle(16);
      rd(`DMSC_ADDR_STAT, 8'h10, 8'h10);
      rd(`DMSC_ADDR_P_RES_H, 8'hff, 8'hff);
      wr(`DMSC_ADDR_MODE, 8'h00);
      idle(2);
      rd(`DMSC_ADDR_STAT, 8'h10, 8'h00);
      // calibrations
      ref_low = 1'b0;
      p_ext = 1'b0;
      pval = 16'($urandom());
      wr(`DMSC_ADDR_MODE, 8'h24);
      idle(3);
      check("input connect", {5'h00, conn}, 8'h01);
      idle(16);
      rd(`DMSC_ADDR_STAT, 8'hff, 8'ha0);
      rd(`DMSC_ADDR_MODE, 8'hff, 8'h20);
      rd(`DMSC_ADDR_P_OFS_H, 8'hff, pval[15:8]);
      wr(`DMSC_ADDR_MODE, 8'h25);
      idle(3);
      check("input connect", {5'h00, conn}, 8'h04);
      idle(16);
      rd(`DMSC_ADDR_P_GN_H, 8'hff, pval[15:8]);
      pval = 16'($urandom());
      wr(`DMSC_ADDR_MODE, 8'h26);
      idle(3);
      check("input connect", {5'h00, conn}, 8'h00);
      idle(16);
      rd(`DMSC_ADDR_P_OFS_M, 8'hff, pval[7:0]);
      wr(`DMSC_ADDR_MODE, 8'h22);
      rd(`DMSC_ADDR_STAT, 8'ha0, 8'h00);
      idle(16);
      // auxiliary calibration with the temperature sensor selected must fail
      aux_temp = 1'b1;
      wr(`DMSC_ADDR_MODE, 8'h14);
      idle(16);
      rd(`DMSC_ADDR_STAT, 8'hff, 8'h64);
      rd(`DMSC_ADDR_A_OFS_H, 8'hff, 8'h80);
      aux_temp = 1'b0;
      // auxiliary config write restarts the auxiliary side only
      wr(`DMSC_ADDR_MODE, 8'h33);
      idle(4);
      #1;
      aux_cfg_wr = 1'b1;
      @(posedge ref_clk);
      #1;
      aux_cfg_wr = 1'b0;
      check("aux restart", {7'h00, a_mrst}, 8'h01);
      check("primary undisturbed", {7'h00, p_mrst}, 8'h00);
      idle(16);
      print_verdict();
   end
endmodule : dmsc_mode_status_bench
